//--- verilog/fpmc_pkg.sv
// Function
// - Five-digit display, four keys read.
// - Held increase/decrease repeats, speeding up over time.
// - Top layer steps through eight modes.
// - Confirm enters second layer, back returns.
// - Parameter mode selects number, confirm shows value.
// - Each step changes value by one, except on the motor model, where it toggles the restore code.
// - Confirm stores modified value, display flashes twice.
// - Stored value takes effect after power cycle.
// - Monitor offers 23 screens with live values.
// - Distinct relay, main circuit, line voltage codes.
// - Analog zeroing measures offset, writes to store.
// - Hold confirm over 3 s, show done.
// - Encoder reset clears multi-turn; single-turn by option.
// - Battery alarm clear after 3 s hold.
// - Power-on reads motor identity, selects model.
// - Unlock, default code, 5 s hold restores defaults.
// - Motor model parameter is read-only to operator.
package fpmc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 250_000_000;
	localparam int T_TICK_MS = 1;
	localparam int T_DEBOUNCE_MS = 10;
	localparam int T_REP_FIRST_MS = 500;
	localparam int T_REP_SLOW_MS = 200;
	localparam int T_REP_FAST_AFTER_MS = 2000;
	localparam int T_REP_FAST_MS = 50;
	localparam int T_HOLD_ACT_MS = 3000;
	localparam int T_HOLD_DEF_MS = 5000;
	localparam int T_FLASH_MS = 250;
	localparam int HC_W = 13;
	localparam int DB_W = 4;
	localparam logic [3:0] FLASH_STORE = 4'h4;
	localparam logic [3:0] FLASH_DEF = 4'h6;

	// ----------------------------------------------------------------
	// Keys, modes, parameters, screens
	// ----------------------------------------------------------------
	localparam int NKEY = 4;
	localparam int K_UP = 0;
	localparam int K_DN = 1;
	localparam int K_BACK = 2;
	localparam int K_SET = 3;
	localparam logic [2:0] MODE_PARAM = 3'h0;
	localparam logic [2:0] MODE_MON = 3'h1;
	localparam logic [2:0] MODE_AZERO = 3'h2;
	localparam logic [2:0] MODE_ENC = 3'h3;
	localparam logic [7:0] PASSWORD_IDX = 8'h00;
	localparam logic [7:0] MOTOR_PARAM_IDX = 8'h01;
	localparam logic [7:0] SPEED_OFS_IDX = 8'h27;
	localparam logic [7:0] TORQ_OFS_IDX = 8'h2D;
	localparam logic [15:0] PASSWORD_UNLOCK = 16'h0181;
	localparam logic [15:0] DEF_RESTORE_CODE = 16'hFFFF;
	localparam logic [7:0] NMON = 8'h17;
	localparam logic [7:0] MON_RELAY = 8'h14;
	localparam logic [7:0] MON_MAIN = 8'h15;
	localparam logic [7:0] MON_LINE = 8'h16;

	// ----------------------------------------------------------------
	// Register map and events
	// ----------------------------------------------------------------
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_STATUS = 5'h04;
	localparam logic [4:0] REG_INT_EN = 5'h08;
	localparam logic [4:0] REG_INT_CLR = 5'h0C;
	localparam logic [4:0] REG_MENU = 5'h10;
	localparam logic [4:0] REG_PARAM_SEL = 5'h14;
	localparam logic [4:0] REG_PARAM_ACT = 5'h18;
	localparam logic [4:0] REG_PARAM_STO = 5'h1C;
	localparam int NEV = 5;
	localparam int EV_STORE = 0;
	localparam int EV_ZERO = 1;
	localparam int EV_ENC = 2;
	localparam int EV_DEF = 3;
	localparam int EV_MOTOR = 4;

	// ----------------------------------------------------------------
	// Display text, five ASCII characters (TXT_M_AUX a three-character prefix), leftmost in the top byte
	// ----------------------------------------------------------------
	localparam logic [39:0] TXT_BUSY = 40'h2D2D2D2D2D;
	localparam logic [39:0] TXT_DONE = 40'h646F6E4520;
	localparam logic [39:0] TXT_DEF = 40'h6445462D20;
	localparam logic [39:0] TXT_M_PARAM = 40'h50412D2020;
	localparam logic [39:0] TXT_M_MON = 40'h64502D2D20;
	localparam logic [39:0] TXT_M_AZERO = 40'h412D413020;
	localparam logic [39:0] TXT_M_ENC = 40'h462D202020;
	localparam logic [23:0] TXT_M_AUX = 24'h466E2D;
	localparam logic [39:0] TXT_Z_SPD = 40'h412D535064;
	localparam logic [39:0] TXT_Z_TRQ = 40'h412D547271;
	localparam logic [39:0] TXT_E_RST = 40'h462D544553;
	localparam logic [39:0] TXT_E_ALM = 40'h462D434C72;
	localparam logic [39:0] TXT_RL_ON = 40'h724C2D6F6E;
	localparam logic [39:0] TXT_RL_OFF = 40'h724C6F4620;
	localparam logic [39:0] TXT_RL_ALM = 40'h724C2D4572;
	localparam logic [39:0] TXT_RN_ON = 40'h726E2D6F6E;
	localparam logic [39:0] TXT_RN_UNCH = 40'h726E6F4620;
	localparam logic [39:0] TXT_RN_DIS = 40'h726E2D4348;
	localparam logic [39:0] TXT_RN_ALM = 40'h726E2D4572;
	localparam logic [39:0] TXT_UV_ON = 40'h552D6F6E20;
	localparam logic [39:0] TXT_UV_LOW = 40'h554C6F5520;
	localparam logic [39:0] TXT_UV_ALM = 40'h552D457272;

	typedef enum logic [3:0] {
		ST_BOOT, ST_MOTOR, ST_TOP, ST_PSEL, ST_PEDIT, ST_FLASH, ST_MSEL, ST_MSHOW,
		ST_ZSEL, ST_ZRUN, ST_ESEL, ST_DONE, ST_AUX
	} fpmc_state_e;

endpackage : fpmc_pkg

//--- verilog/fpmc_top.sv
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
module fpmc_top
	import fpmc_pkg::*;
#(
	parameter int NPARAM = 64, // Parameters in the store.
	parameter int PW = 16, // Parameter width.
	parameter int MS_CYC = CLK_HZ / 1000 * T_TICK_MS, // Clocks per millisecond tick.
	parameter int HOLD_DEF_MS = T_HOLD_DEF_MS // Hold time for default restore.
)(
	input wire logic MCLK, // System clock.
	input wire logic NRST, // Asynchronous reset, active low.
	input wire logic [4:0] AVS_ADDRESS, // Byte address.
	input wire logic AVS_READ, // Read request.
	input wire logic AVS_WRITE, // Write request.
	input wire logic [31:0] AVS_WRITEDATA, // Write data.
	output logic [31:0] AVS_READDATA, // Read data.
	output logic AVS_WAITREQUEST, // Stall.
	input wire logic KEY_UP, // Increase key, high when pressed.
	input wire logic KEY_DOWN, // Decrease key.
	input wire logic KEY_BACK, // Back key.
	input wire logic KEY_SET, // Confirm key.
	output logic [39:0] DISP_TEXT, // Five ASCII characters.
	output logic DISP_ON, // Display lit.
	output logic NVM_RD, // Boot read request.
	output logic [7:0] NVM_RADDR, // Boot read index.
	input wire logic [PW-1:0] NVM_RDATA, // Boot read data.
	input wire logic NVM_RVALID, // Boot read data valid.
	output logic NVM_WE, // Store write pulse.
	output logic [7:0] NVM_WADDR, // Store write index.
	output logic [PW-1:0] NVM_WDATA, // Store write data.
	output logic MOTOR_ID_REQ, // Motor identification request.
	input wire logic MOTOR_ID_VALID, // Identification ready.
	input wire logic [PW-1:0] MOTOR_ID, // Identified motor model.
	output logic ZERO_START, // Start analog offset measurement.
	output logic ZERO_TORQUE, // Zero torque input, else speed.
	input wire logic ZERO_DONE, // Measurement finished.
	input wire logic [PW-1:0] ZERO_OFFSET, // Measured offset.
	output logic ENC_MT_CLR, // Clear multi-turn count.
	output logic ENC_ST_CLR, // Clear single-turn count.
	output logic ENC_ALM_CLR, // Clear battery alarm.
	output logic DEF_RESTORE, // Restore defaults at next power-up.
	output logic [7:0] MON_SEL, // Chosen monitor screen.
	input wire logic [19:0] MON_VALUE, // Live monitored value.
	input wire logic [1:0] RELAY_STATE, // 0 on, 1 off, else alarm.
	input wire logic [1:0] MAIN_STATE, // 0 on, 1 uncharged, 2 disabled, 3 alarm.
	input wire logic [1:0] LINE_STATE, // 0 normal, 1 low, else alarm.
	output logic IRQ // Interrupt, level.
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	localparam int DIV_W = $clog2(MS_CYC);

	typedef struct packed {
		logic [DIV_W-1:0] div;
		logic [NKEY-1:0] kstab;
		logic [NKEY-1:0][DB_W-1:0] dcnt;
		logic [NKEY-1:0][HC_W-1:0] hold;
		logic [NKEY-1:0][HC_W-1:0] rep;
		fpmc_state_e st;
		fpmc_state_e ret;
		logic [2:0] mode;
		logic [7:0] idx;
		logic [PW-1:0] val;
		logic modified;
		logic [HC_W-1:0] fcnt;
		logic [3:0] fph;
		logic disp_on;
		logic [39:0] text;
		logic nvm_we;
		logic [7:0] nvm_waddr;
		logic [PW-1:0] nvm_wdata;
		logic motor_req;
		logic zero_start;
		logic zero_torque;
		logic enc_mt;
		logic enc_st;
		logic enc_alm;
		logic def_req;
		logic ctrl_st;
		logic [NEV-1:0] sts;
		logic [NEV-1:0] inten;
		logic [7:0] psel;
		logic ack;
		logic [31:0] rdata;
		logic [NPARAM-1:0][PW-1:0] act;
		logic [NPARAM-1:0][PW-1:0] sto;
	} fpmc_regs_s;

	fpmc_regs_s r;
	fpmc_regs_s next_r;
	logic [NKEY-1:0] kin;
	logic [NKEY-1:0] press;
	logic [NKEY-1:0] step;
	logic tick;
	logic long_act;
	logic long_def;
	logic up;
	logic dn;
	logic [NEV-1:0] ev;
	logic [NEV-1:0] clr;
	logic req;

	assign kin = {KEY_SET, KEY_BACK, KEY_DOWN, KEY_UP};
	assign req = AVS_READ | AVS_WRITE;

	function automatic logic [7:0] hex_ch(input logic [3:0] n);
		hex_ch = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction : hex_ch

	function automatic logic [39:0] mode_txt(input logic [2:0] m);
		case (m)
			MODE_PARAM: mode_txt = TXT_M_PARAM;
			MODE_MON: mode_txt = TXT_M_MON;
			MODE_AZERO: mode_txt = TXT_M_AZERO;
			MODE_ENC: mode_txt = TXT_M_ENC;
			default: mode_txt = {TXT_M_AUX, 5'h06, m, 8'h20};
		endcase
	endfunction : mode_txt

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_r = r;
		next_r.nvm_we = 1'b0;
		next_r.motor_req = 1'b0;
		next_r.zero_start = 1'b0;
		next_r.enc_mt = 1'b0;
		next_r.enc_st = 1'b0;
		next_r.enc_alm = 1'b0;
		next_r.def_req = 1'b0;
		ev = '0;
		clr = '0;
		press = '0;
		step = '0;
		tick = (r.div == DIV_W'(MS_CYC - 1));
		next_r.div = tick ? '0 : r.div + 1'b1;

		// The millisecond tick paces debounce, repeat and hold timing alike.
		for (int k = 0; k < NKEY; k++) begin
			if (kin[k] == r.kstab[k]) begin
				next_r.dcnt[k] = '0;
			end else if (tick) begin
				if (r.dcnt[k] == DB_W'(T_DEBOUNCE_MS - 1)) begin
					next_r.kstab[k] = kin[k];
					next_r.dcnt[k] = '0;
				end else begin
					next_r.dcnt[k] = r.dcnt[k] + 1'b1;
				end
			end
			press[k] = next_r.kstab[k] & ~r.kstab[k];
			step[k] = press[k];
			if (press[k]) begin
				next_r.hold[k] = '0;
				next_r.rep[k] = HC_W'(T_REP_FIRST_MS);
			end else if (r.kstab[k] && tick) begin
				if (r.hold[k] != '1) begin
					next_r.hold[k] = r.hold[k] + 1'b1;
				end
				if (r.rep[k] == HC_W'(1)) begin
					step[k] = 1'b1;
					next_r.rep[k] = (r.hold[k] >= HC_W'(T_REP_FAST_AFTER_MS)) ?
						HC_W'(T_REP_FAST_MS) : HC_W'(T_REP_SLOW_MS);
				end else begin
					next_r.rep[k] = r.rep[k] - 1'b1;
				end
			end
		end
		up = step[K_UP];
		dn = step[K_DN];
		long_act = r.kstab[K_SET] & tick & (r.hold[K_SET] == HC_W'(T_HOLD_ACT_MS - 1));
		long_def = r.kstab[K_SET] & tick & (r.hold[K_SET] == HC_W'(HOLD_DEF_MS - 1));

		case (r.st)
			ST_BOOT: begin
				if (NVM_RVALID) begin
					next_r.act[r.idx] = NVM_RDATA;
					next_r.sto[r.idx] = NVM_RDATA;
					if (r.idx == 8'(NPARAM - 1)) begin
						next_r.idx = '0;
						next_r.motor_req = 1'b1;
						next_r.st = ST_MOTOR;
					end else begin
						next_r.idx = r.idx + 1'b1;
					end
				end
			end
			ST_MOTOR: begin
				if (MOTOR_ID_VALID) begin
					next_r.act[MOTOR_PARAM_IDX] = MOTOR_ID;
					next_r.sto[MOTOR_PARAM_IDX] = MOTOR_ID;
					next_r.nvm_we = 1'b1;
					next_r.nvm_waddr = MOTOR_PARAM_IDX;
					next_r.nvm_wdata = MOTOR_ID;
					ev[EV_MOTOR] = 1'b1;
					next_r.st = ST_TOP;
				end
			end
			ST_TOP: begin
				if (up) begin
					next_r.mode = r.mode + 1'b1;
				end else if (dn) begin
					next_r.mode = r.mode - 1'b1;
				end else if (press[K_SET]) begin
					next_r.idx = '0;
					case (r.mode)
						MODE_PARAM: next_r.st = ST_PSEL;
						MODE_MON: next_r.st = ST_MSEL;
						MODE_AZERO: next_r.st = ST_ZSEL;
						MODE_ENC: next_r.st = ST_ESEL;
						default: next_r.st = ST_AUX;
					endcase
				end
			end
			ST_PSEL: begin
				if (up) begin
					next_r.idx = (r.idx == 8'(NPARAM - 1)) ? '0 : r.idx + 1'b1;
				end else if (dn) begin
					next_r.idx = (r.idx == '0) ? 8'(NPARAM - 1) : r.idx - 1'b1;
				end else if (press[K_SET]) begin
					next_r.val = r.sto[r.idx];
					next_r.modified = 1'b0;
					next_r.st = ST_PEDIT;
				end else if (press[K_BACK]) begin
					next_r.st = ST_TOP;
				end
			end
			ST_PEDIT: begin
				if (r.idx == MOTOR_PARAM_IDX) begin
					// Only the restore code may be dialled in, and only when unlocked.
					if ((up || dn) && r.sto[PASSWORD_IDX] == PW'(PASSWORD_UNLOCK)) begin
						next_r.val = (r.val == PW'(DEF_RESTORE_CODE)) ?
							r.sto[MOTOR_PARAM_IDX] : PW'(DEF_RESTORE_CODE);
					end else if (long_def && r.val == PW'(DEF_RESTORE_CODE)) begin
						next_r.def_req = 1'b1;
						ev[EV_DEF] = 1'b1;
						next_r.disp_on = 1'b0;
						next_r.fph = FLASH_DEF;
						next_r.fcnt = '0;
						next_r.ret = ST_PSEL;
						next_r.st = ST_FLASH;
					end else if (press[K_BACK]) begin
						next_r.st = ST_PSEL;
					end
				end else if (up) begin
					next_r.val = r.val + 1'b1;
					next_r.modified = 1'b1;
				end else if (dn) begin
					next_r.val = r.val - 1'b1;
					next_r.modified = 1'b1;
				end else if (press[K_SET]) begin
					if (r.modified) begin
						// The running copy stays until the next boot load.
						next_r.sto[r.idx] = r.val;
						next_r.nvm_we = 1'b1;
						next_r.nvm_waddr = r.idx;
						next_r.nvm_wdata = r.val;
						ev[EV_STORE] = 1'b1;
						next_r.modified = 1'b0;
						next_r.disp_on = 1'b0;
						next_r.fph = FLASH_STORE;
						next_r.fcnt = '0;
						next_r.ret = ST_PEDIT;
						next_r.st = ST_FLASH;
					end else begin
						next_r.st = ST_PSEL;
					end
				end else if (press[K_BACK]) begin
					next_r.st = ST_PSEL;
				end
			end
			ST_FLASH: begin
				if (tick) begin
					if (r.fcnt == HC_W'(T_FLASH_MS - 1)) begin
						next_r.fcnt = '0;
						if (r.fph == 4'h1) begin
							next_r.disp_on = 1'b1;
							next_r.st = r.ret;
						end else begin
							next_r.disp_on = ~r.disp_on;
							next_r.fph = r.fph - 1'b1;
						end
					end else begin
						next_r.fcnt = r.fcnt + 1'b1;
					end
				end
			end
			ST_MSEL: begin
				if (up) begin
					next_r.idx = (r.idx == NMON - 1'b1) ? '0 : r.idx + 1'b1;
				end else if (dn) begin
					next_r.idx = (r.idx == '0) ? NMON - 1'b1 : r.idx - 1'b1;
				end else if (press[K_SET]) begin
					next_r.st = ST_MSHOW;
				end else if (press[K_BACK]) begin
					next_r.st = ST_TOP;
				end
			end
			ST_MSHOW: begin
				if (press[K_BACK]) begin
					next_r.st = ST_MSEL;
				end
			end
			ST_ZSEL: begin
				if (up || dn) begin
					next_r.idx = {7'h00, ~r.idx[0]};
				end else if (long_act) begin
					next_r.zero_start = 1'b1;
					next_r.zero_torque = r.idx[0];
					next_r.st = ST_ZRUN;
				end else if (press[K_BACK]) begin
					next_r.st = ST_TOP;
				end
			end
			ST_ZRUN: begin
				if (ZERO_DONE) begin
					next_r.sto[r.idx[0] ? TORQ_OFS_IDX : SPEED_OFS_IDX] = ZERO_OFFSET;
					next_r.nvm_we = 1'b1;
					next_r.nvm_waddr = r.idx[0] ? TORQ_OFS_IDX : SPEED_OFS_IDX;
					next_r.nvm_wdata = ZERO_OFFSET;
					ev[EV_ZERO] = 1'b1;
					next_r.st = ST_DONE;
				end else if (press[K_BACK]) begin
					next_r.st = ST_ZSEL;
				end
			end
			ST_ESEL: begin
				if (up || dn) begin
					next_r.idx = {7'h00, ~r.idx[0]};
				end else if (!r.idx[0] && press[K_SET]) begin
					next_r.enc_mt = 1'b1;
					next_r.enc_st = r.ctrl_st;
					ev[EV_ENC] = 1'b1;
					next_r.st = ST_DONE;
				end else if (r.idx[0] && long_act) begin
					next_r.enc_alm = 1'b1;
					ev[EV_ENC] = 1'b1;
					next_r.st = ST_DONE;
				end else if (press[K_BACK]) begin
					next_r.st = ST_TOP;
				end
			end
			ST_DONE: begin
				if (press[K_BACK]) begin
					next_r.st = (r.mode == MODE_AZERO) ? ST_ZSEL : ST_ESEL;
				end
			end
			ST_AUX: begin
				if (press[K_BACK]) begin
					next_r.st = ST_TOP;
				end
			end
			default: begin
				next_r.st = ST_TOP;
			end
		endcase

		// Display follows the registered state, one clock behind the menu.
		case (r.st)
			ST_TOP, ST_AUX: next_r.text = mode_txt(r.mode);
			ST_PSEL: next_r.text = {16'h5041, hex_ch(r.idx[7:4]), hex_ch(r.idx[3:0]), 8'h20};
			ST_PEDIT: begin
				if (r.idx == MOTOR_PARAM_IDX && r.val == PW'(DEF_RESTORE_CODE)) begin
					next_r.text = TXT_DEF;
				end else begin
					next_r.text = {8'h20, hex_ch(r.val[15:12]), hex_ch(r.val[11:8]),
						hex_ch(r.val[7:4]), hex_ch(r.val[3:0])};
				end
			end
			ST_FLASH: next_r.text = r.text;
			ST_MSEL: next_r.text = {16'h642D, hex_ch(r.idx[7:4]), hex_ch(r.idx[3:0]), 8'h20};
			ST_MSHOW: begin
				if (r.idx == MON_RELAY) begin
					case (RELAY_STATE)
						2'h0: next_r.text = TXT_RL_ON;
						2'h1: next_r.text = TXT_RL_OFF;
						default: next_r.text = TXT_RL_ALM;
					endcase
				end else if (r.idx == MON_MAIN) begin
					case (MAIN_STATE)
						2'h0: next_r.text = TXT_RN_ON;
						2'h1: next_r.text = TXT_RN_UNCH;
						2'h2: next_r.text = TXT_RN_DIS;
						default: next_r.text = TXT_RN_ALM;
					endcase
				end else if (r.idx == MON_LINE) begin
					case (LINE_STATE)
						2'h0: next_r.text = TXT_UV_ON;
						2'h1: next_r.text = TXT_UV_LOW;
						default: next_r.text = TXT_UV_ALM;
					endcase
				end else begin
					next_r.text = {hex_ch(MON_VALUE[19:16]), hex_ch(MON_VALUE[15:12]),
						hex_ch(MON_VALUE[11:8]), hex_ch(MON_VALUE[7:4]),
						hex_ch(MON_VALUE[3:0])};
				end
			end
			ST_ZSEL, ST_ZRUN: next_r.text = r.idx[0] ? TXT_Z_TRQ : TXT_Z_SPD;
			ST_ESEL: next_r.text = r.idx[0] ? TXT_E_ALM : TXT_E_RST;
			ST_DONE: next_r.text = TXT_DONE;
			default: next_r.text = TXT_BUSY;
		endcase

		// --------------------------------------------------------------
		// Register bus: read data is taken on the first edge, writes
		// land on the edge after the one at which the stall is dropped.
		// --------------------------------------------------------------
		next_r.ack = req & ~r.ack;
		if (AVS_READ && !r.ack) begin
			case (AVS_ADDRESS)
				REG_CTRL: next_r.rdata = {31'h0, r.ctrl_st};
				REG_STATUS: next_r.rdata = {{(32 - NEV){1'b0}}, r.sts};
				REG_INT_EN: next_r.rdata = {{(32 - NEV){1'b0}}, r.inten};
				REG_MENU: next_r.rdata = {17'h0, r.st, r.mode, r.idx};
				REG_PARAM_SEL: next_r.rdata = {24'h0, r.psel};
				REG_PARAM_ACT: next_r.rdata = (r.psel < 8'(NPARAM)) ?
					{{(32 - PW){1'b0}}, r.act[r.psel]} : 32'h0;
				REG_PARAM_STO: next_r.rdata = (r.psel < 8'(NPARAM)) ?
					{{(32 - PW){1'b0}}, r.sto[r.psel]} : 32'h0;
				default: next_r.rdata = 32'h0;
			endcase
		end
		if (AVS_WRITE && r.ack) begin
			case (AVS_ADDRESS)
				REG_CTRL: next_r.ctrl_st = AVS_WRITEDATA[0];
				REG_INT_EN: next_r.inten = AVS_WRITEDATA[NEV-1:0];
				REG_INT_CLR: clr = AVS_WRITEDATA[NEV-1:0];
				REG_PARAM_SEL: next_r.psel = AVS_WRITEDATA[7:0];
				default: ;
			endcase
		end
		// A new event in the clearing cycle survives the clear.
		next_r.sts = (r.sts & ~clr) | ev;
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			r <= '0;
			r.disp_on <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign AVS_READDATA = r.rdata;
	assign AVS_WAITREQUEST = req & ~r.ack;
	assign DISP_TEXT = r.text;
	assign DISP_ON = r.disp_on;
	assign NVM_RD = (r.st == ST_BOOT);
	assign NVM_RADDR = r.idx;
	assign NVM_WE = r.nvm_we;
	assign NVM_WADDR = r.nvm_waddr;
	assign NVM_WDATA = r.nvm_wdata;
	assign MOTOR_ID_REQ = r.motor_req;
	assign ZERO_START = r.zero_start;
	assign ZERO_TORQUE = r.zero_torque;
	assign ENC_MT_CLR = r.enc_mt;
	assign ENC_ST_CLR = r.enc_st;
	assign ENC_ALM_CLR = r.enc_alm;
	assign DEF_RESTORE = r.def_req;
	assign MON_SEL = r.idx;
	assign IRQ = |(r.sts & r.inten);

endmodule : fpmc_top

//--- tb/fpmc_chk.sv
`timescale 1ns/10ps
module fpmc_chk import fpmc_pkg::*; #(
	parameter int MS_CYC = 10, // Clocks per ms.
	parameter int HOLD_DEF_MS = 5000 // Default hold.
)(
	input wire logic MCLK, // Clock.
	input wire logic NRST, // Reset.
	input wire logic [4:0] AVS_ADDRESS, // Address.
	input wire logic AVS_READ, // Read.
	input wire logic AVS_WRITE, // Write.
	input wire logic [31:0] AVS_READDATA, // Read data.
	input wire logic AVS_WAITREQUEST, // Stall.
	input wire logic KEY_SET, // Confirm key.
	input wire logic NVM_WE, // Store write.
	input wire logic [7:0] NVM_WADDR, // Store index.
	input wire logic ZERO_START, // Zero start.
	input wire logic ZERO_TORQUE, // Zero torque.
	input wire logic ZERO_DONE, // Zero done.
	input wire logic ENC_MT_CLR, // Multi-turn clear.
	input wire logic ENC_ST_CLR, // Single-turn clear.
	input wire logic ENC_ALM_CLR, // Alarm clear.
	input wire logic DEF_RESTORE, // Defaults.
	input wire logic MOTOR_ID_VALID // Ident.
);
	logic [31:0] held;
	logic [31:0] next_held;
	// Raw key time bounds the debounced hold.
	always_comb next_held = KEY_SET ? held + 32'h1 : 32'h0;
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) held <= 32'h0;
		else held <= next_held;
	end
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!NRST);
	sequence s_stall; AVS_WAITREQUEST; endsequence
	sequence s_ack; !AVS_WAITREQUEST; endsequence
	property p_wait; $rose(AVS_READ | AVS_WRITE) |-> s_stall ##1 s_ack; endproperty
	a_wait: assert property (p_wait) else $error("bus answer late");
	property p_clr; AVS_READ && AVS_ADDRESS == REG_INT_CLR && !AVS_WAITREQUEST
		|-> AVS_READDATA == 32'h0; endproperty
	a_clr: assert property (p_clr) else $error("clear register reads nonzero");
	property p_pulse; NVM_WE |=> !NVM_WE; endproperty
	a_pulse: assert property (p_pulse) else $error("store write too long");
	property p_nomtr; NVM_WE && !$past(MOTOR_ID_VALID) |-> NVM_WADDR != MOTOR_PARAM_IDX; endproperty
	a_nomtr: assert property (p_nomtr) else $error("motor model written");
	property p_zwr; ZERO_DONE |-> ##[1:8] NVM_WE
		&& NVM_WADDR == (ZERO_TORQUE ? TORQ_OFS_IDX : SPEED_OFS_IDX); endproperty
	a_zwr: assert property (p_zwr) else $error("offset not stored");
	property p_zhold; ZERO_START |-> held >= 32'(T_HOLD_ACT_MS * MS_CYC); endproperty
	a_zhold: assert property (p_zhold) else $error("zeroing started early");
	property p_ahold; ENC_ALM_CLR |-> held >= 32'(T_HOLD_ACT_MS * MS_CYC); endproperty
	a_ahold: assert property (p_ahold) else $error("alarm cleared early");
	property p_dhold; DEF_RESTORE |-> held >= 32'(HOLD_DEF_MS * MS_CYC); endproperty
	a_dhold: assert property (p_dhold) else $error("restore too early");
	property p_stmt; ENC_ST_CLR |-> ENC_MT_CLR; endproperty
	a_stmt: assert property (p_stmt) else $error("single-turn alone");
endmodule : fpmc_chk
bind fpmc_top fpmc_chk #(.MS_CYC(MS_CYC), .HOLD_DEF_MS(HOLD_DEF_MS)) u_fpmc_chk (.MCLK, .NRST,
	.AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_READDATA, .AVS_WAITREQUEST, .KEY_SET, .NVM_WE,
	.NVM_WADDR, .ZERO_START, .ZERO_TORQUE, .ZERO_DONE, .ENC_MT_CLR, .ENC_ST_CLR, .ENC_ALM_CLR,
	.DEF_RESTORE, .MOTOR_ID_VALID);

//--- tb/fpmc_far.sv
`timescale 1ns/10ps
module fpmc_far import fpmc_pkg::*; (
	input wire logic MCLK, // Clock.
	input wire logic NVM_RD, // Boot load.
	input wire logic [7:0] NVM_RADDR, // Word index.
	output logic [15:0] NVM_RDATA, // Word.
	output logic NVM_RVALID, // Word valid.
	input wire logic MOTOR_ID_REQ, // Ident request.
	output logic MOTOR_ID_VALID, // Ident ready.
	output logic [15:0] MOTOR_ID, // Motor model.
	input wire logic ZERO_START, // Measure start.
	output logic ZERO_DONE, // Measure done.
	output logic [15:0] ZERO_OFFSET // Offset.
);
	logic tog = 1'b0;
	logic [3:0] mc = 4'h0;
	logic [3:0] zc = 4'h0;
	always @(posedge MCLK) begin
		tog <= NVM_RD & ~tog;
		mc <= MOTOR_ID_REQ ? 4'h3 : mc - 4'(mc != 4'h0);
		zc <= ZERO_START ? 4'h6 : zc - 4'(zc != 4'h0);
	end
	// Words come every other cycle; idle lines carry inverted data so stale reads fail.
	assign NVM_RVALID = tog & NVM_RD;
	assign NVM_RDATA = {8'h01, NVM_RVALID ? NVM_RADDR : ~NVM_RADDR};
	assign MOTOR_ID_VALID = mc == 4'h1;
	assign MOTOR_ID = MOTOR_ID_VALID ? 16'h0028 : 16'hFFD7;
	assign ZERO_DONE = zc == 4'h1;
	assign ZERO_OFFSET = ZERO_DONE ? 16'h0123 : 16'hFEDC;
endmodule : fpmc_far

//--- tb/test_front_panel_menu_controller.sv
`timescale 1ns/10ps
module test_front_panel_menu_controller import fpmc_pkg::*; ();
	localparam int MSC = 10;
	typedef struct {logic w; logic [4:0] a; logic [31:0] d; logic [31:0] e;} fpmc_row_s;
	// Reads expect e; writes ignore it.
	fpmc_row_s rows [11] = '{'{1'b0, REG_CTRL, 32'h0, 32'h0}, '{1'b0, REG_STATUS, 32'h0, 32'h10},
		'{1'b1, REG_INT_EN, 32'h1F, 32'h0}, '{1'b0, REG_INT_EN, 32'h0, 32'h1F},
		'{1'b1, REG_STATUS, 32'hFF, 32'h0}, '{1'b1, REG_INT_CLR, 32'h10, 32'h0},
		'{1'b0, REG_STATUS, 32'h0, 32'h0}, '{1'b0, REG_INT_CLR, 32'h0, 32'h0},
		'{1'b0, 5'h02, 32'h0, 32'h0}, '{1'b1, REG_INT_EN, 32'h1, 32'h0},
		'{1'b0, REG_MENU, 32'h0, 32'h1000}};
	logic MCLK = 1'b0, NRST = 1'b0, rd = 1'b0, wr = 1'b0;
	logic wt, irq, don, on_q, nvrd, rv, nwe, mreq, mv, zst, zdn;
	logic [3:0] keys = 4'h0;
	logic [4:0] adr = 5'h0;
	logic [31:0] wd = 32'h0, rdat, q;
	logic [39:0] txt;
	logic [7:0] nra, nwa, we_a;
	logic [15:0] nvd, nwd, mid, zofs, we_d;
	int n_errors = 0, n_checks = 0, n_fall = 0;
	fpmc_top #(.MS_CYC(MSC)) u_fpmc_top (.MCLK, .NRST, .AVS_ADDRESS(adr), .AVS_READ(rd),
		.AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wt),
		.KEY_UP(keys[K_UP]), .KEY_DOWN(keys[K_DN]), .KEY_BACK(keys[K_BACK]),
		.KEY_SET(keys[K_SET]), .DISP_TEXT(txt), .DISP_ON(don), .NVM_RD(nvrd), .NVM_RADDR(nra),
		.NVM_RDATA(nvd), .NVM_RVALID(rv), .NVM_WE(nwe), .NVM_WADDR(nwa), .NVM_WDATA(nwd),
		.MOTOR_ID_REQ(mreq), .MOTOR_ID_VALID(mv), .MOTOR_ID(mid), .ZERO_START(zst),
		.ZERO_TORQUE(), .ZERO_DONE(zdn), .ZERO_OFFSET(zofs), .ENC_MT_CLR(), .ENC_ST_CLR(),
		.ENC_ALM_CLR(), .DEF_RESTORE(), .MON_SEL(), .MON_VALUE(20'h12345), .RELAY_STATE(2'h0),
		.MAIN_STATE(2'h1), .LINE_STATE(2'h2), .IRQ(irq));
	fpmc_far u_fpmc_far (.MCLK, .NVM_RD(nvrd), .NVM_RADDR(nra), .NVM_RDATA(nvd),
		.NVM_RVALID(rv), .MOTOR_ID_REQ(mreq), .MOTOR_ID_VALID(mv), .MOTOR_ID(mid),
		.ZERO_START(zst), .ZERO_DONE(zdn), .ZERO_OFFSET(zofs));
	initial forever #2 MCLK = ~MCLK;
	always @(posedge MCLK) begin
		on_q <= don;
		if (on_q === 1'b1 && don === 1'b0) n_fall++;
		if (nwe === 1'b1) {we_a, we_d} <= {nwa, nwd};
	end
	task automatic chk(input string n, input logic [39:0] s, input logic [39:0] e);
		n_checks++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] r);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		do @(posedge MCLK); while (wt !== 1'b0);
		r = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge MCLK);
	endtask : bus
	task automatic rchk(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, q);
		chk("register", {8'h0, q}, {8'h0, e});
	endtask : rchk
	task automatic mchk(input logic [6:0] e);
		bus(1'b0, REG_MENU, 32'h0, q);
		chk("menu", {33'h0, q[14:8]}, {33'h0, e});
	endtask : mchk
	task automatic go(input int k, input int n, input int ms);
		repeat (n) begin
			keys[k] <= 1'b1;
			repeat (ms * MSC) @(posedge MCLK);
			keys[k] <= 1'b0;
			repeat (20 * MSC) @(posedge MCLK);
		end
	endtask : go
	task automatic stop_test;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test
	initial begin
		repeat (80000) @(posedge MCLK);
		n_errors++;
		stop_test;
	end
	initial begin
		repeat (3) @(posedge MCLK);
		NRST <= 1'b1;
		do bus(1'b0, REG_MENU, 32'h0, q); while (q[14:11] !== 4'(ST_TOP));
		foreach (rows[i]) begin
			bus(rows[i].w, rows[i].a, rows[i].d, q);
			if (!rows[i].w) chk("register", {8'h0, q}, {8'h0, rows[i].e});
		end
		for (int i = 1; i <= 8; i++) begin
			go(K_UP, 1, 15);
			mchk(7'h10 | 7'(i % 8));
		end
		go(K_SET, 1, 15);
		mchk(7'h18);
		go(K_BACK, 1, 15);
		mchk(7'h10);
		go(K_SET, 1, 15);
		go(K_UP, 2, 15);
		rchk(REG_MENU, 32'h1802);
		go(K_SET, 1, 15);
		chk("text", txt, 40'h2030313032);
		go(K_UP, 1, 15);
		chk("text", txt, 40'h2030313033);
		go(K_UP, 1, 750);
		chk("text", txt, 40'h2030313036);
		n_fall = 0;
		go(K_SET, 1, 15);
		repeat (1200 * MSC) @(posedge MCLK);
		chk("store", {we_a, 16'h0, we_d}, 40'h0200000106);
		chk("flash", 40'(n_fall), 40'h2);
		chk("irq", {39'h0, irq}, 40'h1);
		bus(1'b1, REG_INT_CLR, 32'h1, q);
		chk("irq", {39'h0, irq}, 40'h0);
		bus(1'b1, REG_PARAM_SEL, 32'h2, q);
		rchk(REG_PARAM_ACT, 32'h0102);
		rchk(REG_PARAM_STO, 32'h0106);
		go(K_BACK, 2, 15);
		go(K_UP, 2, 15);
		go(K_SET, 1, 15);
		go(K_SET, 1, 3100);
		chk("zero", {we_a, 16'h0, we_d}, {SPEED_OFS_IDX, 32'h0123});
		chk("text", txt, TXT_DONE);
		rchk(REG_STATUS, 32'h2);
		go(K_BACK, 2, 15);
		go(K_DN, 1, 15);
		go(K_SET, 1, 15);
		go(K_DN, 1, 15);
		go(K_SET, 1, 15);
		chk("text", txt, TXT_UV_ALM);
		stop_test;
	end
endmodule : test_front_panel_menu_controller
